// >>> core/dst_acq_core.sv
// Behaviour
// - With scanning on, the channel steps down from the top channel to 0, then restarts at the top.
// - The scan length is set by the top channel so that 2 to 8 channels are covered.
// - A scan counter holds the channel and drives the multiplexer, stepping only when scanning is on.
// - Reading the digital input register returns the live levels of the four input lines.
// - Writing the digital output register stores four bits and drives them until the next write.
// - Counter 0 paces conversions internally; counters 1 and 2 are free for the user.
// - The gate of counter 1 is held active, so it always counts once programmed.
// - Three independent 16-bit counters with several modes are set up through one 8-bit mode register.
// - Counter 0 is clocked by a 1 MHz timebase made from the board clock.
// - The same 1 MHz timebase is driven out to the connector for counters 1 and 2.
// - Each counter has its own clock, gate and output, indexed 0 to 2.
// - The pacer counter pulses when its count reaches 1 and reloads its count, giving 2 us to 65536 us intervals.
// - Each 12-bit result is sign-extended to 16 bits into a 16-word FIFO; not-empty shows in status.
// - A result arriving at a full FIFO is lost and sets a sticky overflow flag.
`timescale 1ns/100ps
`default_nettype none

module dst_acq_core
	import dst_pkg::*;
#(
	parameter int FIFO_DEPTH = 16,
	parameter int FIFO_AW = 4,
	parameter int CH_W = 3
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Host programmed I/O
	input wire dst_io_req_t host_req,
	output logic [7:0] host_rdata,
	// Digital port
	input wire logic [3:0] dig_in,
	output logic [3:0] dig_out,
	// Converter and multiplexer
	input wire logic external_convert_trigger_n,
	input wire dst_adc_res_t adc_res,
	output logic adc_start,
	output logic [CH_W-1:0] mux_channel,
	// Counters and timebase
	input wire logic [1:0] user_counter_clk,
	input wire logic user_counter_gate2,
	output logic [1:0] user_counter_out,
	output logic pacer_counter_output,
	output logic timebase_out
);

	// ----------------------------------------------------------------
	// Timebase divider
	// ----------------------------------------------------------------
	logic [7:0] div_reg, div_next;
	logic tb_reg, tb_next;
	logic tick_reg, tick_next;

	// 1 MHz square wave plus a one-clock tick in the clock before its rising edge
	always_comb begin
		div_next = div_reg + 8'h01;
		tick_next = 1'b0;
		if (div_reg == 8'(TB_DIV_CYC - 1)) begin
			div_next = 8'h00;
			tick_next = 1'b1;
		end
		tb_next = (div_reg < 8'(TB_HALF_CYC));
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			div_reg <= 8'h00;
			tb_reg <= 1'b0;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			tb_reg <= tb_next;
			tick_reg <= tick_next;
		end
	end

	// ----------------------------------------------------------------
	// Host register state
	// ----------------------------------------------------------------
	logic [7:0] ctrl_reg, ctrl_next;
	logic [3:0] dout_reg, dout_next;
	logic [7:0] rdata_reg, rdata_next;
	logic ovf_reg, ovf_next;
	logic [FIFO_AW:0] fcnt_reg, fcnt_next;
	logic [FIFO_AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
	logic [15:0] fifo_word;
	logic push, pop, full, wr_hit_ctl;
	logic acq_en, scan_en;
	logic [CH_W-1:0] top_ch;

	assign acq_en = ctrl_reg[CTRL_ACQ_BIT];
	assign scan_en = ctrl_reg[CTRL_SCAN_BIT];
	assign top_ch = ctrl_reg[CTRL_CH_LSB +: CH_W];
	assign full = (fcnt_reg == (FIFO_AW+1)'(FIFO_DEPTH));

	// True when a host access hits a given register
	function automatic logic hit(input logic strobe, input logic [3:0] a,
			input logic [3:0] ofs);
		hit = strobe && (a == ofs);
	endfunction

	assign wr_hit_ctl = hit(host_req.wr, host_req.addr, OFS_STATUS);

	// Control, output port, read data, FIFO pointers and overflow
	always_comb begin
		ctrl_next = ctrl_reg;
		dout_next = dout_reg;
		rdata_next = rdata_reg;
		wptr_next = wptr_reg;
		rptr_next = rptr_reg;
		fcnt_next = fcnt_reg;
		ovf_next = ovf_reg;
		pop = hit(host_req.rd, host_req.addr, OFS_FIFO_HI) && (fcnt_reg != '0);
		if (hit(host_req.wr, host_req.addr, OFS_ACQ_CTRL)) begin
			ctrl_next = host_req.wdata;
		end
		if (hit(host_req.wr, host_req.addr, OFS_DIG_OUT)) begin
			dout_next = host_req.wdata[3:0];
		end
		// Read data; write-only and unmapped offsets read zero
		if (host_req.rd) begin
			if (host_req.addr == OFS_FIFO_LO) begin
				rdata_next = fifo_word[7:0];
			end else if (host_req.addr == OFS_FIFO_HI) begin
				rdata_next = fifo_word[15:8];
			end else if (host_req.addr == OFS_STATUS) begin
				rdata_next = 8'h00;
				rdata_next[STAT_NE_BIT] = (fcnt_reg != '0);
				rdata_next[STAT_OVF_BIT] = ovf_reg;
				rdata_next[STAT_RUN_BIT] = acq_en;
				rdata_next[STAT_CH_LSB +: CH_W] = mux_channel;
			end else if (host_req.addr == OFS_ACQ_CTRL) begin
				rdata_next = ctrl_reg;
			end else if (host_req.addr == OFS_DIG_IN) begin
				rdata_next = {4'h0, dig_in};
			end else begin
				rdata_next = 8'h00;
			end
		end
		// A push to a full FIFO is dropped and flagged
		if (push && full) begin
			ovf_next = 1'b1;
		end else if (wr_hit_ctl && host_req.wdata[STAT_OVF_BIT]) begin
			ovf_next = 1'b0;
		end
		if (push && !full) begin
			wptr_next = wptr_reg + 1'b1;
		end
		if (pop) begin
			rptr_next = rptr_reg + 1'b1;
		end
		if ((push && !full) && !pop) begin
			fcnt_next = fcnt_reg + 1'b1;
		end else if (pop && !(push && !full)) begin
			fcnt_next = fcnt_reg - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= ACQ_CTRL_RST;
			dout_reg <= DIG_OUT_RST;
			rdata_reg <= 8'h00;
			wptr_reg <= '0;
			rptr_reg <= '0;
			fcnt_reg <= '0;
			ovf_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			dout_reg <= dout_next;
			rdata_reg <= rdata_next;
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			fcnt_reg <= fcnt_next;
			ovf_reg <= ovf_next;
		end
	end

	// Result storage; sign extension of the 12-bit code
	dst_fifo_mem #(
		.WIDTH(16),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.we(push && !full),
		.waddr(wptr_reg),
		.wdata({{4{adc_res.code[11]}}, adc_res.code}),
		.raddr(rptr_next),
		.rdata(fifo_word)
	);

	// ----------------------------------------------------------------
	// Counters 0 to 2
	// ----------------------------------------------------------------
	logic [2:0] cnt_tick, cnt_gate, cnt_out;
	logic [1:0] uclk_reg;
	logic [2:0] mode_sel;

	// Counter 1 and 2 clocks are pins; a rising level is one count
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			uclk_reg <= 2'b00;
		end else begin
			uclk_reg <= user_counter_clk;
		end
	end

	// Per-counter clock and gate sources
	always_comb begin
		cnt_tick = {user_counter_clk & ~uclk_reg, tick_reg};
		cnt_gate = {user_counter_gate2, 1'b1, acq_en};
		mode_sel = 3'b000;
		if (hit(host_req.wr, host_req.addr, OFS_CNT_MODE)) begin
			mode_sel[host_req.wdata[MODE_SEL_LSB +: 2]] = 1'b1;
		end
	end

	// Three identical counters, each with its own clock, gate and output
	for (genvar gi = 0; gi < 3; gi++) begin : g_cnt
		logic [15:0] val_reg, val_next, rld_reg, rld_next;
		logic [2:0] mode_reg, mode_next;
		logic hi_reg, hi_next, arm_reg, arm_next, load_reg, load_next;
		logic out_reg, out_next;
		logic data_wr;

		assign data_wr = hit(host_req.wr, host_req.addr, OFS_CNT0 + 4'(gi));

		// Low byte then high byte arm the counter; count loads on next tick
		always_comb begin
			val_next = val_reg;
			rld_next = rld_reg;
			mode_next = mode_reg;
			hi_next = hi_reg;
			arm_next = arm_reg;
			load_next = load_reg;
			out_next = out_reg;
			if (mode_sel[gi]) begin
				mode_next = host_req.wdata[MODE_FIELD_LSB +: 3];
				hi_next = 1'b0;
				arm_next = 1'b0;
				out_next = 1'b1;
			end else if (data_wr && !hi_reg) begin
				rld_next[7:0] = host_req.wdata;
				hi_next = 1'b1;
			end else if (data_wr) begin
				rld_next[15:8] = host_req.wdata;
				hi_next = 1'b0;
				arm_next = 1'b1;
				load_next = 1'b1;
			end else if (cnt_tick[gi] && arm_reg && cnt_gate[gi]) begin
				if (load_reg) begin
					val_next = rld_reg;
					load_next = 1'b0;
					out_next = 1'b1;
				end else if (mode_reg == CNT_MODE_SQUARE) begin
					// Half period by double decrement; odd counts run long
					if (val_reg <= 16'h0002) begin
						val_next = rld_reg;
						out_next = !out_reg;
					end else begin
						val_next = val_reg - 16'h0002;
					end
				end else if (val_reg == 16'h0001) begin
					val_next = rld_reg;
					out_next = 1'b0;
				end else begin
					val_next = val_reg - 16'h0001;
					out_next = 1'b1;
				end
			end
		end

		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				val_reg <= CNT_RST;
				rld_reg <= CNT_RST;
				mode_reg <= CNT_MODE_RST;
				hi_reg <= 1'b0;
				arm_reg <= 1'b0;
				load_reg <= 1'b0;
				out_reg <= 1'b1;
			end else begin
				val_reg <= val_next;
				rld_reg <= rld_next;
				mode_reg <= mode_next;
				hi_reg <= hi_next;
				arm_reg <= arm_next;
				load_reg <= load_next;
				out_reg <= out_next;
			end
		end

		assign cnt_out[gi] = out_reg;
	end

	// ----------------------------------------------------------------
	// Conversion control and scan counter
	// ----------------------------------------------------------------
	dst_cnv_state_t cnv_reg, cnv_next;
	logic [CH_W-1:0] ch_reg, ch_next, top_eff;
	logic start_reg, start_next;
	logic pace_prev_reg, ext_prev_reg;
	logic trig;

	// Top channel below 1 would scan one channel only
	assign top_eff = (top_ch < CH_W'(SCAN_TOP_MIN)) ? CH_W'(SCAN_TOP_MIN)
		: top_ch;
	assign trig = acq_en && ((cnt_out[0] && !pace_prev_reg)
		|| (external_convert_trigger_n && !ext_prev_reg));
	assign push = (cnv_reg == CNV_BUSY) && adc_res.done;

	// Triggers while busy are dropped, as the rate limit allows
	always_comb begin
		cnv_next = cnv_reg;
		ch_next = ch_reg;
		start_next = 1'b0;
		if (!scan_en) begin
			ch_next = top_ch;
		end
		case (cnv_reg)
			CNV_IDLE: begin
				if (trig) begin
					start_next = 1'b1;
					cnv_next = CNV_BUSY;
					if (scan_en) begin
						// Step in the same cycle as start so the mux settles early
						ch_next = (ch_reg == '0) ? top_eff
							: ch_reg - 1'b1;
					end
				end
			end
			CNV_BUSY: begin
				if (adc_res.done) begin
					cnv_next = CNV_IDLE;
				end
			end
			default: begin
				cnv_next = CNV_IDLE;
			end
		endcase
		if (!acq_en && scan_en && cnv_reg == CNV_IDLE) begin
			ch_next = top_eff;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnv_reg <= CNV_IDLE;
			ch_reg <= '0;
			start_reg <= 1'b0;
			pace_prev_reg <= 1'b1;
			ext_prev_reg <= 1'b1;
		end else begin
			cnv_reg <= cnv_next;
			ch_reg <= ch_next;
			start_reg <= start_next;
			pace_prev_reg <= cnt_out[0];
			ext_prev_reg <= external_convert_trigger_n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all from flip-flops
	// ----------------------------------------------------------------
	assign host_rdata = rdata_reg;
	assign dig_out = dout_reg;
	assign adc_start = start_reg;
	assign mux_channel = ch_reg;
	assign user_counter_out = cnt_out[2:1];
	assign pacer_counter_output = cnt_out[0];
	assign timebase_out = tb_reg;

endmodule

`default_nettype wire

// >>> core/dst_fifo_mem.sv
`timescale 1ns/100ps
`default_nettype none

// Result storage: one write port, read data from a register
module dst_fifo_mem #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Write side
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	// Read side
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] mem [DEPTH];

	// Storage holds no reset; the read register loads mem[raddr] every clock, written or not
	always_ff @(posedge clock) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Read data register follows the read pointer one clock later
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= '0;
		end else begin
			rdata <= mem[raddr];
		end
	end

endmodule

`default_nettype wire

// >>> core/dst_pkg.sv
package dst_pkg;

	// ----------------------------------------------------------------
	// Host port register indices (8-bit programmed I/O)
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_FIFO_LO = 4'h0;
	localparam logic [3:0] OFS_FIFO_HI = 4'h1;
	localparam logic [3:0] OFS_STATUS = 4'h2;
	localparam logic [3:0] OFS_ACQ_CTRL = 4'h3;
	localparam logic [3:0] OFS_DIG_IN = 4'h4;
	localparam logic [3:0] OFS_DIG_OUT = 4'h5;
	localparam logic [3:0] OFS_CNT0 = 4'h8;
	localparam logic [3:0] OFS_CNT_MODE = 4'hB;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_ACQ_BIT = 0;
	localparam int CTRL_SCAN_BIT = 1;
	localparam int CTRL_CH_LSB = 2;
	localparam int STAT_NE_BIT = 0;
	localparam int STAT_OVF_BIT = 1;
	localparam int STAT_RUN_BIT = 2;
	localparam int STAT_CH_LSB = 4;
	localparam int MODE_FIELD_LSB = 1;
	localparam int MODE_SEL_LSB = 6;

	// ----------------------------------------------------------------
	// Reset values and counter modes
	// ----------------------------------------------------------------
	localparam logic [7:0] ACQ_CTRL_RST = 8'h00;
	localparam logic [3:0] DIG_OUT_RST = 4'h0;
	localparam logic [15:0] CNT_RST = 16'h0000;
	localparam logic [2:0] CNT_MODE_RST = 3'h2;
	localparam logic [2:0] CNT_MODE_RATE = 3'h2;
	localparam logic [2:0] CNT_MODE_SQUARE = 3'h3;
	localparam logic [2:0] SCAN_TOP_MIN = 3'h1;

	// ----------------------------------------------------------------
	// Timing: 1 MHz timebase from the 100 MHz clock
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int TB_PERIOD_NS = 1000;
	localparam int TB_DIV_CYC = TB_PERIOD_NS / CLK_PERIOD_NS;
	localparam int TB_HALF_CYC = TB_DIV_CYC / 2;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} dst_io_req_t;

	typedef struct packed {
		logic done;
		logic [11:0] code;
	} dst_adc_res_t;

	typedef enum logic {CNV_IDLE, CNV_BUSY} dst_cnv_state_t;

endpackage

// >>> testbench/daq_scan_timing_dio_tb.sv
`timescale 1ns/100ps
`default_nettype none

module daq_scan_timing_dio_tb;
	import dst_pkg::*;
	logic clock = 1'b0, rst_n = 1'b0, ext_n = 1'b1, p;
	logic [3:0] dig_in = 4'h0, dig_out;
	logic [7:0] rd, lo;
	logic [2:0] ch, top;
	logic [1:0] uc_clk = 2'h0, uc_out;
	logic gate2 = 1'b1, adc_start, pacer, tbase;
	logic [2:0] mux;
	dst_io_req_t req;
	dst_adc_res_t adc = '0;
	int failures = 0, samples_checked = 0, seed = 96307, n, v, i, cv;
	logic [15:0] exp_q[$];
	logic [7:0] rd_w;
	always #5 clock = ~clock;
	dst_host_model host (.clock(clock), .host_rdata(rd_w), .host_req(req));
	dst_acq_core dut (.clock(clock), .rst_n(rst_n), .host_req(req),
		.host_rdata(rd_w), .dig_in(dig_in), .dig_out(dig_out),
		.external_convert_trigger_n(ext_n), .adc_res(adc),
		.adc_start(adc_start), .mux_channel(mux),
		.user_counter_clk(uc_clk), .user_counter_gate2(gate2),
		.user_counter_out(uc_out), .pacer_counter_output(pacer),
		.timebase_out(tbase));
	// User counter clocks kept moving so their logic is exercised
	always #500 uc_clk = ~uc_clk;
	task automatic end_sim();
		if (failures == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Converter: answers three cycles after a start; model keeps 16 words
	always @(posedge clock) begin
		if (adc_start === 1'b1) begin
			repeat (3) @(posedge clock);
			cv = $random(seed);
			#1 adc = '{done: 1'b1, code: cv[11:0]};
			if (exp_q.size() < 16)
				exp_q.push_back({{4{cv[11]}}, cv[11:0]});
			@(posedge clock);
			#1 adc.done = 1'b0;
		end
	end
	// Trigger spacing leaves the converter idle before the next one
	task automatic trig();
		@(posedge clock);
		#1 ext_n = 1'b0;
		@(posedge clock);
		#1 ext_n = 1'b1;
		for (n = 0; n < 10 && adc_start !== 1'b1; n++)
			@(posedge clock) #1;
		if (n == 10) begin
			failures++;
			end_sim();
		end
		ch = (ch == 3'h0) ? top : ch - 3'h1;
		check("mux_channel", 16'(mux), 16'(ch));
		repeat (8) @(posedge clock);
	endtask
	task automatic wait_rise(output int c);
		for (c = 1; c < 1000; c++) begin
			p = pacer;
			@(posedge clock) #1;
			if (!p && pacer) break;
		end
		if (c == 1000) begin
			failures++;
			end_sim();
		end
	endtask
	initial begin
		repeat (20) @(posedge clock);
		#1 rst_n = 1'b1;
		check("dig_out rst", 16'(dig_out), 16'(DIG_OUT_RST));
		check("pacer rst", 16'(pacer), 16'h0001);
		check("user out rst", 16'(uc_out), 16'h0003);
		// Digital port: stored output, live input
		for (i = 0; i < 4; i++) begin
			v = $random(seed);
			dig_in = v[3:0];
			host.wr_reg(OFS_DIG_OUT, 8'(v[7:4]));
			check("dig_out", 16'(dig_out), 16'(v[7:4]));
			host.rd_reg(OFS_DIG_IN, rd);
			check("dig_in", 16'(rd), 16'(v[3:0]));
		end
		// Scan of four channels, top 3, then overflow past 16 results
		top = 3'h3;
		ch = top;
		host.wr_reg(OFS_ACQ_CTRL, 8'h0E);
		host.wr_reg(OFS_ACQ_CTRL, 8'h0F);
		check("mux top", 16'(mux), 16'(top));
		for (i = 0; i < 17; i++)
			trig();
		host.rd_reg(OFS_STATUS, rd);
		check("status ovf", 16'(rd[1:0]), 16'h0003);
		for (i = 0; i < 16; i++) begin
			host.rd_reg(OFS_FIFO_LO, lo);
			host.rd_reg(OFS_FIFO_HI, rd);
			repeat (2) @(posedge clock);
			check("fifo word", {rd, lo}, exp_q.pop_front());
		end
		host.wr_reg(OFS_STATUS, 8'h02);
		host.rd_reg(OFS_STATUS, rd);
		check("status empty", 16'(rd[1:0]), 16'h0000);
		// Pacer: mode 2, count 2, one period is two 1 MHz ticks
		host.wr_reg(OFS_CNT_MODE, 8'h04);
		host.wr_reg(OFS_CNT0, 8'h02);
		host.wr_reg(OFS_CNT0, 8'h00);
		wait_rise(v);
		wait_rise(v);
		wait_rise(v);
		check("pacer period", 16'(v), 16'(2 * TB_DIV_CYC));
		end_sim();
	end
endmodule

bind dst_acq_core dst_acq_core_asserts #(.CH_W(CH_W)) u_chk (
	.clock(clock), .rst_n(rst_n), .host_req(host_req),
	.host_rdata(host_rdata), .dig_in(dig_in), .dig_out(dig_out),
	.external_convert_trigger_n(external_convert_trigger_n),
	.adc_start(adc_start), .mux_channel(mux_channel),
	.pacer_counter_output(pacer_counter_output),
	.timebase_out(timebase_out));

`default_nettype wire

// >>> testbench/dst_acq_core_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module dst_acq_core_asserts
	import dst_pkg::*;
#(
	parameter int CH_W = 3
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Host port
	input wire dst_io_req_t host_req,
	input wire logic [7:0] host_rdata,
	// Pins
	input wire logic [3:0] dig_in,
	input wire logic [3:0] dig_out,
	input wire logic external_convert_trigger_n,
	input wire logic adc_start,
	input wire logic [CH_W-1:0] mux_channel,
	input wire logic pacer_counter_output,
	input wire logic timebase_out
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic ext_reg, pac_reg, tb_reg, seen_reg, seen_next, rise;
	logic [2:0] hist_reg, hist_next;
	logic [7:0] cnt_reg, cnt_next;
	// Trigger history and timebase half-period count
	always_comb begin
		rise = (external_convert_trigger_n & ~ext_reg) |
			(pacer_counter_output & ~pac_reg);
		hist_next = {hist_reg[1:0], rise};
		cnt_next = (timebase_out != tb_reg) ? 8'h00 : cnt_reg + 8'h01;
		seen_next = seen_reg | (timebase_out != tb_reg);
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			// Trigger and pacer pins idle high, timebase low; no half period is timed until a first change
			{ext_reg, pac_reg, tb_reg, seen_reg} <= 4'hC;
			hist_reg <= 3'h0;
			cnt_reg <= 8'h00;
		end else begin
			{ext_reg, pac_reg, tb_reg} <= {external_convert_trigger_n,
				pacer_counter_output, timebase_out};
			seen_reg <= seen_next;
			hist_reg <= hist_next;
			cnt_reg <= cnt_next;
		end
	end
	// Mode 2 output: low for exactly one 100-clock tick
	sequence pacer_low_seq;
		##99 !pacer_counter_output ##1 pacer_counter_output;
	endsequence
	dout_write_a: assert property (host_req.wr && host_req.addr == OFS_DIG_OUT |=> dig_out == $past(host_req.wdata[3:0])) else $error("dig_out missed write");
	dout_hold_a: assert property (!(host_req.wr && host_req.addr == OFS_DIG_OUT) |=> $stable(dig_out)) else $error("dig_out moved");
	din_read_a: assert property (host_req.rd && host_req.addr == OFS_DIG_IN |=> host_rdata == {4'h0, $past(dig_in)}) else $error("dig_in read wrong");
	start_pulse_a: assert property (adc_start |=> !adc_start) else $error("start too long");
	start_cause_a: assert property (adc_start |-> rise || hist_reg != 3'h0) else $error("start without trigger");
	scan_step_a: assert property (adc_start && $past(mux_channel) != '0 && mux_channel != $past(mux_channel) |-> mux_channel == $past(mux_channel) - CH_W'(1)) else $error("bad scan step");
	chan_hold_a: assert property (!adc_start && !$past(host_req.wr) && !$past(host_req.wr, 2) && !$past(host_req.wr, 3) |-> $stable(mux_channel)) else $error("channel moved");
	timebase_half_a: assert property (timebase_out != tb_reg && seen_reg |-> cnt_reg == 8'(TB_HALF_CYC - 1)) else $error("timebase half period");
	pacer_low_a: assert property ($fell(pacer_counter_output) |-> pacer_low_seq) else $error("pacer low width");
endmodule

`default_nettype wire

// >>> testbench/dst_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module dst_host_model
	import dst_pkg::*;
(
	// Clock
	input wire logic clock,
	// Register port
	input wire logic [7:0] host_rdata,
	output var dst_io_req_t host_req
);
	initial host_req = '0;
	// One-cycle write strobe, launched just after an edge
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		#1 host_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		#1 host_req = '0;
	endtask
	// Read data is taken one edge after the strobe was sampled
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge clock);
		#1 host_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clock);
		#1 host_req = '0;
		@(posedge clock);
		#1 d = host_rdata;
	endtask
endmodule

`default_nettype wire
